// *** hw/liu_ctrl_pin_decode.sv ***
// control pin decoder: host bus pins or hardware strap settings
// ----------------------------------------------------------------
// How it works
// - mode pins pick hardware, serial or parallel control
// - parallel mode: data pins are bidirectional host bus
// - parallel mode: six address pins, bit five top
// - pulse pin picks template and 75/120 ohm
// - receiver power-down pin: low runs, high off
// - pattern pins: normal, all ones, PRBS, off
// - termination pin: internal when 0, external when 1
// - attenuator pins: off, rx broad, rx narrow, tx
// - attenuator pins act only in hardware mode
// - monitor pin: 0 dB or 26 dB gain
// - reset pin low over 100 ns resets
// ----------------------------------------------------------------
//
// The Wishbone register port and the register addresses were left to the implementer.
`default_nettype none

`include "liu_defines.svh"

module liu_ctrl_pin_decode #(
  parameter int unsigned RST_MIN_CYC = `LIU_RST_CYC
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // mode and reset pins
  input  wire logic                   control_if_sel_hi_i,
  input  wire logic                   control_if_sel_lo_i,
  input  wire logic                   hw_reset_n_i,
  // shared address pins, hardware straps in hardware mode
  input  wire logic [5:0]             addr_pins_i,
  // shared data pins
  input  wire logic [7:0]             data_pins_i,
  output logic      [7:0]             data_pins_o,
  output logic                        data_pins_oe_o,
  // host strobes
  input  wire logic                   host_cs_n_i,
  input  wire logic                   host_strb_n_i,
  input  wire logic                   host_rw_wr_n_i,
  // dedicated hardware control pins
  input  wire logic                   pulse_template_select_ch1_i,
  input  wire logic                   pulse_template_select_ch2_i,
  input  wire logic                   termination_select_ch1_i,
  input  wire logic                   termination_select_ch2_i,
  input  wire logic                   jitter_atten_sel_hi_i,
  input  wire logic                   jitter_atten_sel_lo_i,
  input  wire logic                   monitor_gain_ch1_i,
  input  wire logic                   monitor_gain_ch2_i,
  // wishbone slave
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [3:0]             adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic      [31:0]            dat_o,
  output logic                        ack_o,
  // decoded settings
  output logic      [1:0]             mode_o,
  output liu_pkg::liu_chan_cfg_t      ch1_cfg_o,
  output liu_pkg::liu_chan_cfg_t      ch2_cfg_o,
  output liu_pkg::liu_ja_cfg_t        ja_cfg_o,
  output logic                        chip_reset_o,
  // host register access toward the core
  output logic      [5:0]             host_addr_o,
  output logic      [7:0]             host_wdata_o,
  output logic                        host_we_o,
  output logic                        host_re_o
);

  initial begin
    if (RST_MIN_CYC < 1) begin
      $error("liu_ctrl_pin_decode: RST_MIN_CYC must be at least 1");
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NPIN = 28;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;

  assign pin_raw = {control_if_sel_hi_i, control_if_sel_lo_i, hw_reset_n_i,
                    host_cs_n_i, host_strb_n_i, host_rw_wr_n_i,
                    pulse_template_select_ch1_i, pulse_template_select_ch2_i,
                    termination_select_ch1_i, termination_select_ch2_i,
                    jitter_atten_sel_hi_i, jitter_atten_sel_lo_i,
                    monitor_gain_ch1_i, monitor_gain_ch2_i,
                    addr_pins_i, data_pins_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= {{2{1'b0}}, 1'b1, {3{1'b1}}, {22{1'b0}}};
      sync2_q <= {{2{1'b0}}, 1'b1, {3{1'b1}}, {22{1'b0}}};
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  logic [1:0] mode_s;
  logic       rst_n_s;
  logic       cs_n_s;
  logic       strb_n_s;
  logic       rw_s;
  logic [1:0] pul_s;
  logic [1:0] term_s;
  logic [1:0] ja_s;
  logic [1:0] mont_s;
  logic [5:0] addr_s;
  logic [7:0] data_s;

  assign mode_s   = sync2_q[27:26];
  assign rst_n_s  = sync2_q[25];
  assign cs_n_s   = sync2_q[24];
  assign strb_n_s = sync2_q[23];
  assign rw_s     = sync2_q[22];
  assign pul_s    = sync2_q[21:20];
  assign term_s   = sync2_q[19:18];
  assign ja_s     = sync2_q[17:16];
  assign mont_s   = sync2_q[15:14];
  assign addr_s   = sync2_q[13:8];
  assign data_s   = sync2_q[7:0];

  // ----------------------------------------------------------------
  // hardware reset pin filter
  // ----------------------------------------------------------------
  logic chip_rst;

  liu_rst_filter #(
    .MIN_CYC (RST_MIN_CYC)
  ) u_rst_filter (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .pin_rst_n_i (rst_n_s),
    .reset_o     (chip_rst)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic hw_mode;
  logic par_mode;
  logic ds_style;

  assign hw_mode  = (mode_s == `LIU_MODE_HW);
  assign par_mode = (mode_s == `LIU_MODE_PAR_DS) || (mode_s == `LIU_MODE_PAR_RW);
  assign ds_style = (mode_s == `LIU_MODE_PAR_DS);

  // ----------------------------------------------------------------
  // software configuration register
  // ----------------------------------------------------------------
  // per channel: [0] rx pd, [2:1] pattern, [3] pulse, [4] term, [5] mont
  // channel 2 at [13:8]; attenuator select at [17:16]
  logic [31:0] swcfg_q;
  logic [31:0] swcfg_d;
  logic [7:0]  hostdata_q;
  logic [7:0]  hostdata_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;

  logic wb_req;
  assign wb_req = cyc_i && stb_i && !ack_q;

  always_comb begin
    swcfg_d    = swcfg_q;
    hostdata_d = hostdata_q;
    ack_d      = wb_req;
    rdat_d     = 32'h0000_0000;
    if (wb_req && we_i) begin
      unique case (adr_i)
        `LIU_OFS_SWCFG: begin
          for (int b = 0; b < 4; b++) begin
            if (sel_i[b]) begin
              swcfg_d[8*b +: 8] = dat_i[8*b +: 8];
            end
          end
        end
        `LIU_OFS_HOSTDATA: begin
          if (sel_i[0]) begin
            hostdata_d = dat_i[7:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (wb_req && !we_i) begin
      unique case (adr_i)
        `LIU_OFS_STATUS:   rdat_d = {22'h0, chip_rst, hw_mode, mode_s, addr_s};
        `LIU_OFS_SWCFG:    rdat_d = swcfg_q;
        `LIU_OFS_HOSTDATA: rdat_d = {24'h0, hostdata_q};
        default:           rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || chip_rst) begin
      swcfg_q    <= `LIU_SWCFG_RST;
      hostdata_q <= `LIU_HOSTDATA_RST;
    end else begin
      swcfg_q    <= swcfg_d;
      hostdata_q <= hostdata_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ----------------------------------------------------------------
  // per channel setting decode
  // ----------------------------------------------------------------
  liu_pkg::liu_chan_cfg_t cfg_d [2];
  liu_pkg::liu_chan_cfg_t cfg_q [2];
  liu_pkg::liu_ja_cfg_t   ja_d;
  liu_pkg::liu_ja_cfg_t   ja_q;
  logic [1:0]             ja_code;

  // channel 2 pattern sits on address pins 1:0, power-downs on 4 and 2
  logic [1:0] rpd_pins;
  logic [1:0] patt_ch2;
  assign rpd_pins = {addr_s[4], addr_s[2]};
  assign patt_ch2 = {addr_s[1], addr_s[0]};

  generate
    for (genvar c = 0; c < 2; c++) begin : g_chan
      logic [5:0] sw;
      logic [1:0] patt;
      assign sw   = swcfg_q[8*c +: 6];
      // channel 1 pattern has no shared pin, taken from the register
      assign patt = (c == 1) ? patt_ch2 : sw[2:1];

      always_comb begin
        cfg_d[c] = cfg_q[c];
        if (hw_mode) begin
          cfg_d[c].rx_powerdown  = rpd_pins[c];
          cfg_d[c].tx_pattern    = liu_pkg::liu_pattern_t'(patt);
          cfg_d[c].pulse_e1_120  = (c == 0) ? pul_s[1] : pul_s[0];
          cfg_d[c].term_120_ohm  = (c == 0) ? pul_s[1] : pul_s[0];
          cfg_d[c].term_external = (c == 0) ? term_s[1] : term_s[0];
          cfg_d[c].monitor_26db  = (c == 0) ? mont_s[1] : mont_s[0];
        end else begin
          cfg_d[c].rx_powerdown  = sw[0];
          cfg_d[c].tx_pattern    = liu_pkg::liu_pattern_t'(sw[2:1]);
          cfg_d[c].pulse_e1_120  = sw[3];
          cfg_d[c].term_120_ohm  = sw[3];
          cfg_d[c].term_external = sw[4];
          cfg_d[c].monitor_26db  = sw[5];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i || chip_rst) begin
          cfg_q[c] <= '0;
        end else begin
          cfg_q[c] <= cfg_d[c];
        end
      end
    end
  endgenerate

  assign ja_code = hw_mode ? ja_s : swcfg_q[17:16];

  always_comb begin
    ja_d = '0;
    unique case (liu_pkg::liu_ja_t'(ja_code))
      liu_pkg::LIU_JA_OFF:           ja_d = '0;
      liu_pkg::LIU_JA_RX_BROAD_64:   ja_d = '{enable: 1'b1, in_tx_path: 1'b0,
                                              narrow_bw: 1'b0, fifo_128: 1'b0};
      liu_pkg::LIU_JA_RX_NARROW_128: ja_d = '{enable: 1'b1, in_tx_path: 1'b0,
                                              narrow_bw: 1'b1, fifo_128: 1'b1};
      liu_pkg::LIU_JA_TX_NARROW_128: ja_d = '{enable: 1'b1, in_tx_path: 1'b1,
                                              narrow_bw: 1'b1, fifo_128: 1'b1};
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || chip_rst) begin
      ja_q <= '0;
    end else begin
      ja_q <= ja_d;
    end
  end

  // ----------------------------------------------------------------
  // parallel host port
  // ----------------------------------------------------------------
  // data-strobe style: strobe low with rw high reads, low writes
  // read/write-strobe style: rd on strobe pin, wr on rw pin
  logic       rd_act;
  logic       wr_act;
  logic       wr_prev_q;
  logic       rd_prev_q;
  logic       drv_d;
  logic       drv_q;
  logic [5:0] haddr_d;
  logic [5:0] haddr_q;
  logic [7:0] hwdat_d;
  logic [7:0] hwdat_q;
  logic       hwe_d;
  logic       hwe_q;
  logic       hre_d;
  logic       hre_q;
  logic [7:0] dout_q;

  always_comb begin
    if (ds_style) begin
      rd_act = par_mode && !cs_n_s && !strb_n_s && rw_s;
      wr_act = par_mode && !cs_n_s && !strb_n_s && !rw_s;
    end else begin
      rd_act = par_mode && !cs_n_s && !strb_n_s;
      wr_act = par_mode && !cs_n_s && !rw_s;
    end
    drv_d   = rd_act;
    haddr_d = par_mode ? addr_s : haddr_q;
    hwdat_d = wr_act ? data_s : hwdat_q;
    hwe_d   = wr_prev_q && !wr_act;
    hre_d   = rd_act && !rd_prev_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || chip_rst) begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      drv_q     <= 1'b0;
      haddr_q   <= 6'h00;
      hwdat_q   <= 8'h00;
      hwe_q     <= 1'b0;
      hre_q     <= 1'b0;
      dout_q    <= 8'h00;
    end else begin
      wr_prev_q <= wr_act;
      rd_prev_q <= rd_act;
      drv_q     <= drv_d;
      haddr_q   <= haddr_d;
      hwdat_q   <= hwdat_d;
      hwe_q     <= hwe_d;
      hre_q     <= hre_d;
      dout_q    <= hostdata_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [1:0] mode_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= `LIU_MODE_HW;
    end else begin
      mode_q <= mode_s;
    end
  end

  assign data_pins_o    = dout_q;
  assign data_pins_oe_o = drv_q;
  assign dat_o          = rdat_q;
  assign ack_o          = ack_q;
  assign mode_o         = mode_q;
  assign ch1_cfg_o      = cfg_q[0];
  assign ch2_cfg_o      = cfg_q[1];
  assign ja_cfg_o       = ja_q;
  assign chip_reset_o   = chip_rst;
  assign host_addr_o    = haddr_q;
  assign host_wdata_o   = hwdat_q;
  assign host_we_o      = hwe_q;
  assign host_re_o      = hre_q;

endmodule

`default_nettype wire

// *** hw/liu_defines.svh ***
// constants for the line interface control pin decoder
`ifndef LIU_DEFINES_SVH
`define LIU_DEFINES_SVH

// ----------------------------------------------------------------
// control interface select codes
// ----------------------------------------------------------------
`define LIU_MODE_HW          2'h0
`define LIU_MODE_SERIAL      2'h1
`define LIU_MODE_PAR_DS      2'h2
`define LIU_MODE_PAR_RW      2'h3

// ----------------------------------------------------------------
// wishbone register offsets (byte addresses)
// ----------------------------------------------------------------
`define LIU_OFS_STATUS       4'h0
`define LIU_OFS_SWCFG        4'h4
`define LIU_OFS_HOSTDATA     4'h8
`define LIU_OFS_RESETCNT     4'hC

// ----------------------------------------------------------------
// register reset values
// ----------------------------------------------------------------
`define LIU_SWCFG_RST        32'h0000_0000
`define LIU_HOSTDATA_RST     8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LIU_CLK_MHZ          50
`define LIU_RST_MIN_NS       100
// longer than the minimum: strictly more than 100 ns low
`define LIU_RST_CYC          ((`LIU_RST_MIN_NS * `LIU_CLK_MHZ + 999) / 1000 + 1)

`endif

// *** hw/liu_pkg.sv ***
// types for the line interface control pin decoder
`default_nettype none

package liu_pkg;

  typedef enum logic [1:0] {
    LIU_PAT_NORMAL,
    LIU_PAT_ALL_ONES,
    LIU_PAT_PRBS,
    LIU_PAT_TX_OFF
  } liu_pattern_t;

  typedef enum logic [1:0] {
    LIU_JA_OFF,
    LIU_JA_RX_BROAD_64,
    LIU_JA_RX_NARROW_128,
    LIU_JA_TX_NARROW_128
  } liu_ja_t;

  // per channel decoded settings
  typedef struct packed {
    logic         rx_powerdown;
    liu_pattern_t tx_pattern;
    logic         term_120_ohm;
    logic         pulse_e1_120;
    logic         term_external;
    logic         monitor_26db;
  } liu_chan_cfg_t;

  // jitter attenuator placement and depth
  typedef struct packed {
    logic    enable;
    logic    in_tx_path;
    logic    narrow_bw;
    logic    fifo_128;
  } liu_ja_cfg_t;

endpackage

`default_nettype wire

// *** hw/liu_rst_filter.sv ***
// reset pin filter: asserts reset only after a long enough low
`default_nettype none

`include "liu_defines.svh"

module liu_rst_filter #(
  parameter int unsigned MIN_CYC = `LIU_RST_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // synchronised pin level, active low
  input  wire logic pin_rst_n_i,
  // filtered reset, active high
  output logic      reset_o
);

  initial begin
    if (MIN_CYC < 1 || MIN_CYC > 255) begin
      $error("liu_rst_filter: MIN_CYC out of range");
    end
  end

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       reset_q;
  logic       reset_d;

  always_comb begin
    cnt_d   = cnt_q;
    reset_d = reset_q;
    if (pin_rst_n_i) begin
      cnt_d   = 8'h00;
      reset_d = 1'b0;
    end else if (cnt_q >= 8'(MIN_CYC - 1)) begin
      reset_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q   <= 8'h00;
      reset_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      reset_q <= reset_d;
    end
  end

  assign reset_o = reset_q;

endmodule

`default_nettype wire

// *** tb/liu_ctrl_pin_decode_monitor.sv ***
// concurrent checks on the control pin decoder ports
`default_nettype none

module liu_ctrl_pin_decode_chk #(
  parameter int unsigned RST_MIN_CYC = 6
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // pins
  input  wire logic                   hw_reset_n_i,
  input  wire logic [5:0]             addr_pins_i,
  input  wire logic                   pulse_template_select_ch1_i,
  input  wire logic                   termination_select_ch1_i,
  input  wire logic                   monitor_gain_ch1_i,
  input  wire logic                   jitter_atten_sel_hi_i,
  input  wire logic                   jitter_atten_sel_lo_i,
  // wishbone
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [3:0]             adr_i,
  input  wire logic [31:0]            dat_o,
  input  wire logic                   ack_o,
  // decoded outputs
  input  wire logic [1:0]             mode_o,
  input  wire liu_pkg::liu_chan_cfg_t ch1_cfg_o,
  input  wire liu_pkg::liu_chan_cfg_t ch2_cfg_o,
  input  wire liu_pkg::liu_ja_cfg_t   ja_cfg_o,
  input  wire logic                   chip_reset_o,
  input  wire logic                   data_pins_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic [7:0] low_cnt_q;
  logic [7:0] low_cnt_d;
  logic       hw_quiet;

  always_comb begin
    low_cnt_d = low_cnt_q;
    if (hw_reset_n_i) low_cnt_d = 8'h00;
    else if (low_cnt_q != 8'hFF) low_cnt_d = low_cnt_q + 8'h01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) low_cnt_q <= 8'h00;
    else low_cnt_q <= low_cnt_d;
  end

  assign hw_quiet = (mode_o == 2'h0) && !chip_reset_o;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  ack_answer_a: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not acknowledged");
  ack_single_a: assert property (
    ack_o |=> !ack_o) else $error("ack held over one cycle");
  unmapped_zero_a: assert property (
    cyc_i && stb_i && !ack_o && !we_i && adr_i == 4'hC |=> dat_o == 32'h0000_0000)
    else $error("unmapped read gave data");
  oe_host_mode_a: assert property (
    data_pins_oe_o |-> mode_o[1]) else $error("data pins driven outside parallel mode");
  rx_powerdown_a: assert property (
    (hw_quiet && $stable(addr_pins_i))[*5] |->
      ch1_cfg_o.rx_powerdown == addr_pins_i[2] && ch2_cfg_o.rx_powerdown == addr_pins_i[4])
    else $error("receiver power down does not follow pins");
  tx_pattern_a: assert property (
    (hw_quiet && $stable(addr_pins_i))[*5] |-> ch2_cfg_o.tx_pattern == addr_pins_i[1:0])
    else $error("transmit pattern does not follow pins");
  ja_decode_a: assert property (
    (hw_quiet && $stable({jitter_atten_sel_hi_i, jitter_atten_sel_lo_i}))[*5] |->
      ja_cfg_o == {jitter_atten_sel_hi_i | jitter_atten_sel_lo_i,
                   jitter_atten_sel_hi_i & jitter_atten_sel_lo_i,
                   jitter_atten_sel_hi_i, jitter_atten_sel_hi_i})
    else $error("attenuator decode wrong");
  ch1_straps_a: assert property (
    (hw_quiet && $stable({pulse_template_select_ch1_i, termination_select_ch1_i,
                          monitor_gain_ch1_i}))[*5] |->
      {ch1_cfg_o.pulse_e1_120, ch1_cfg_o.term_120_ohm, ch1_cfg_o.term_external,
       ch1_cfg_o.monitor_26db} == {pulse_template_select_ch1_i, pulse_template_select_ch1_i,
                                   termination_select_ch1_i, monitor_gain_ch1_i})
    else $error("channel one strap decode wrong");
  rst_long_a: assert property (
    low_cnt_q >= RST_MIN_CYC + 4 |-> chip_reset_o) else $error("long reset low ignored");
  rst_release_a: assert property (
    hw_reset_n_i [*4] |-> !chip_reset_o) else $error("chip reset held after pin release");
endmodule

bind liu_ctrl_pin_decode liu_ctrl_pin_decode_chk #(.RST_MIN_CYC(RST_MIN_CYC)) u_chk (.*);

`default_nettype wire

// *** tb/liu_ctrl_pin_decode_test.sv ***
// testbench for the control pin decoder
`default_nettype none

`include "liu_defines.svh"

module liu_ctrl_pin_decode_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned RST_CYC = `LIU_RST_CYC;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic control_if_sel_hi_i = 1'b0;
  logic control_if_sel_lo_i = 1'b0;
  logic hw_reset_n_i = 1'b1;
  logic pulse_template_select_ch1_i = 1'b0;
  logic pulse_template_select_ch2_i = 1'b0;
  logic termination_select_ch1_i = 1'b0;
  logic termination_select_ch2_i = 1'b0;
  logic jitter_atten_sel_hi_i = 1'b0;
  logic jitter_atten_sel_lo_i = 1'b0;
  logic monitor_gain_ch1_i = 1'b0;
  logic monitor_gain_ch2_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [5:0] addr_pins_i;
  logic [7:0] data_pins_i;
  logic [7:0] data_pins_o;
  logic data_pins_oe_o;
  logic host_cs_n_i;
  logic host_strb_n_i;
  logic host_rw_wr_n_i;
  logic [31:0] dat_o;
  logic ack_o;
  logic [1:0] mode_o;
  liu_pkg::liu_chan_cfg_t ch1_cfg_o;
  liu_pkg::liu_chan_cfg_t ch2_cfg_o;
  liu_pkg::liu_ja_cfg_t ja_cfg_o;
  logic chip_reset_o;
  logic [5:0] host_addr_o;
  logic [7:0] host_wdata_o;
  logic host_we_o;
  logic host_re_o;
  int miscompares = 0;
  int samples_checked = 0;
  int re_seen = 0;
  int we_seen = 0;
  logic [3:0] ja_tbl [4] = '{4'h0, 4'h8, 4'hB, 4'hF};

  // clock keeps running through pin reset
  initial forever #10 clk_i = ~clk_i;

  liu_ctrl_pin_decode #(.RST_MIN_CYC(RST_CYC)) u_dut (.*);

  liu_host_model u_host (.clk_i(clk_i), .dev_data_i(data_pins_o), .dev_oe_i(data_pins_oe_o),
    .addr_o(addr_pins_i), .data_o(data_pins_i), .cs_n_o(host_cs_n_i),
    .strb_n_o(host_strb_n_i), .rw_n_o(host_rw_wr_n_i));

  // pulses seen on the core side of the host port
  always @(posedge clk_i) begin
    re_seen <= re_seen + int'(host_re_o);
    we_seen <= we_seen + int'(host_we_o);
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] wd,
                    output logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= wd;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    d = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic set_mode(input logic [1:0] m);
    control_if_sel_hi_i <= m[1];
    control_if_sel_lo_i <= m[0];
    repeat (6) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic [7:0]  hd;
    logic [1:0]  v;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'({ch1_cfg_o, ch2_cfg_o, ja_cfg_o, mode_o, chip_reset_o}), 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = i[1:0];
      set_mode(v);
      chk(32'(mode_o), 32'(v));
      wb(1'b0, 4'h0, 32'h0, rd);
      chk(32'(rd[8:6]), 32'({v == 2'h0, v}));
    end
    set_mode(2'h0);
    for (int i = 0; i < 4; i++) begin
      v = i[1:0];
      u_host.set_addr({1'b0, v[1], 1'b0, v[0], v});
      {jitter_atten_sel_hi_i, jitter_atten_sel_lo_i} <= v;
      pulse_template_select_ch1_i <= v[0];
      pulse_template_select_ch2_i <= ~v[0];
      termination_select_ch1_i <= v[1];
      termination_select_ch2_i <= v[0];
      monitor_gain_ch1_i <= v[1];
      monitor_gain_ch2_i <= ~v[1];
      repeat (6) @(posedge clk_i);
      chk(32'(ch2_cfg_o.tx_pattern), 32'(v));
      chk(32'({ch1_cfg_o.rx_powerdown, ch2_cfg_o.rx_powerdown}), 32'({v[0], v[1]}));
      chk(32'({ch1_cfg_o.pulse_e1_120, ch1_cfg_o.term_120_ohm, ch2_cfg_o.pulse_e1_120,
               ch2_cfg_o.term_120_ohm}), 32'({v[0], v[0], ~v[0], ~v[0]}));
      chk(32'({ch1_cfg_o.term_external, ch2_cfg_o.term_external}), 32'(v));
      chk(32'({ch1_cfg_o.monitor_26db, ch2_cfg_o.monitor_26db}),
          32'({v[1], ~v[1]}));
      chk(32'(ja_cfg_o), 32'(ja_tbl[i]));
    end
    hw_reset_n_i <= 1'b0;
    // exactly 100 ns low: not long enough
    repeat (RST_CYC - 1) @(posedge clk_i);
    hw_reset_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(chip_reset_o), 32'h0);
    hw_reset_n_i <= 1'b0;
    repeat (RST_CYC + 6) @(posedge clk_i);
    chk(32'({chip_reset_o, ch2_cfg_o}), 32'h80);
    hw_reset_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(32'(chip_reset_o), 32'h0);
    set_mode(2'h2);
    wb(1'b1, 4'h4, 32'h0002_0015, rd);
    repeat (4) @(posedge clk_i);
    chk(32'(ja_cfg_o), 32'hB);
    chk(32'(ch1_cfg_o), 32'h62);
    wb(1'b0, 4'h4, 32'h0, rd);
    chk(rd, 32'h0002_0015);
    wb(1'b1, 4'hC, 32'hFFFF_FFFF, rd);
    wb(1'b0, 4'hC, 32'h0, rd);
    chk(rd, 32'h0);
    wb(1'b1, 4'h8, 32'h0000_00A5, rd);
    u_host.rd(6'h21, hd);
    chk(32'(hd), 32'hA5);
    chk(32'(host_addr_o), 32'h21);
    chk(32'(data_pins_oe_o), 32'h0);
    u_host.wr(6'h3C, 8'h5A, 1'b1);
    chk(32'({host_addr_o, host_wdata_o}), 32'h3C5A);
    set_mode(2'h3);
    u_host.wr(6'h15, 8'hC3, 1'b0);
    chk(32'({host_addr_o, host_wdata_o}), 32'h15C3);
    u_host.rd(6'h2A, hd);
    chk(32'(hd), 32'hA5);
    chk(32'(host_addr_o), 32'h2A);
    chk(32'(re_seen), 32'h2);
    chk(32'(we_seen), 32'h2);
    results();
  end

  initial begin
    #100us;
    miscompares++;
    results();
  end
endmodule

`default_nettype wire

// *** tb/liu_host_model.sv ***
// host microcontroller model on the parallel pins
`default_nettype none

module liu_host_model (
  // clock
  input  wire logic       clk_i,
  // device side of the data pins
  input  wire logic [7:0] dev_data_i,
  input  wire logic       dev_oe_i,
  // pins toward the device
  output logic      [5:0] addr_o,
  output logic      [7:0] data_o,
  output var logic        cs_n_o,
  output var logic        strb_n_o,
  output var logic        rw_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] drive_q = 8'h00;
  logic       drive_en_q = 1'b0;
  logic [7:0] last_q = 8'h00;

  initial begin
    addr_o = 6'h00;
    cs_n_o = 1'b1;
    strb_n_o = 1'b1;
    rw_n_o = 1'b1;
  end

  // released bus shows a changing pattern, never the old value
  assign data_o = dev_oe_i ? dev_data_i : (drive_en_q ? drive_q : ~last_q);
  always @(posedge clk_i) last_q <= data_o;

  task automatic set_addr(input logic [5:0] a);
    addr_o <= a;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    addr_o <= a;
    rw_n_o <= 1'b1;
    cs_n_o <= 1'b0;
    strb_n_o <= 1'b0;
    @(posedge clk_i);
    // data taken at the edge that first sees the drive
    while (dev_oe_i !== 1'b1) begin
      @(posedge clk_i);
    end
    d = data_o;
    cs_n_o <= 1'b1;
    strb_n_o <= 1'b1;
    repeat (5) @(posedge clk_i);
  endtask

  // ds high: data-strobe style, low: write strobe alone
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic ds);
    addr_o <= a;
    drive_q <= d;
    drive_en_q <= 1'b1;
    rw_n_o <= 1'b0;
    cs_n_o <= 1'b0;
    strb_n_o <= !ds;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    strb_n_o <= 1'b1;
    @(posedge clk_i);
    drive_en_q <= 1'b0;
    rw_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

`default_nettype wire
